// *** design/sensor_readout_map.vh ***
// constants for the linear sensor readout sequencer
`ifndef SENSOR_READOUT_MAP_VH
`define SENSOR_READOUT_MAP_VH
`define PIXEL_COUNT 128
`define PIXEL_INDEX_WIDTH 7
`define RESET_PERIOD_CYCLES 18
`define RESET_COUNT_WIDTH 5
`define RESET_COUNT_ZERO 5'h00
`define RESET_COUNT_LOAD 5'h11
`define SHIFT_ZERO 128'h0
`endif

// *** design/linear_sensor_readout_sequencer.v ***
// linear sensor readout sequencer: start capture, 128-stage shift, integrator reset timing
`include "sensor_readout_map.vh"

module linear_sensor_readout_sequencer
(
  input wire clock,
  input wire srst,
  input wire start_pulse,
  output wire [`PIXEL_COUNT-1:0] pixel_select,
  output wire analog_pixel_out_oe,
  output wire [`PIXEL_INDEX_WIDTH-1:0] pixel_index,
  output wire sample_hold,
  output wire integrator_reset,
  output wire frame_done
);

reg [`PIXEL_COUNT-1:0] shift_reg;
reg [`PIXEL_COUNT-1:0] shift_next;
reg oe_reg;
reg oe_next;
reg [`PIXEL_INDEX_WIDTH-1:0] index_reg;
reg [`PIXEL_INDEX_WIDTH-1:0] index_next;
reg hold_reg;
reg hold_next;
reg int_reset_reg;
reg int_reset_next;
reg [`RESET_COUNT_WIDTH-1:0] reset_count_reg;
reg [`RESET_COUNT_WIDTH-1:0] reset_count_next;
reg done_reg;
reg done_next;
integer i;

always @*
begin
  // shift chain: stage 0 takes the start pulse, others step along
  shift_next = {shift_reg[`PIXEL_COUNT-2:0], start_pulse};
  oe_next = |shift_next;
  index_next = {`PIXEL_INDEX_WIDTH{1'b0}};
  for (i = 0; i < `PIXEL_COUNT; i = i + 1)
  begin
    if (shift_next[i])
    begin
      index_next = i[`PIXEL_INDEX_WIDTH-1:0];
    end
  end
  done_next = shift_reg[`PIXEL_COUNT-1];
  hold_next = hold_reg;
  int_reset_next = int_reset_reg;
  reset_count_next = reset_count_reg;
  if (start_pulse)
  begin
    // every sampling switch opens on the same edge
    hold_next = 1'b1;
    int_reset_next = 1'b1;
    // counts down from period minus one so the flag spans the full period
    reset_count_next = `RESET_COUNT_LOAD;
  end
  else if (int_reset_reg)
  begin
    if (reset_count_reg == `RESET_COUNT_ZERO)
    begin
      // reset over: integration restarts for all pixels together
      int_reset_next = 1'b0;
      hold_next = 1'b0;
    end
    else
    begin
      reset_count_next = reset_count_reg - 1'b1;
    end
  end
end

always @(posedge clock)
begin
  if (srst)
  begin
    shift_reg <= `SHIFT_ZERO;
    oe_reg <= 1'b0;
    index_reg <= {`PIXEL_INDEX_WIDTH{1'b0}};
    hold_reg <= 1'b0;
    int_reset_reg <= 1'b0;
    reset_count_reg <= `RESET_COUNT_ZERO;
    done_reg <= 1'b0;
  end
  else
  begin
    shift_reg <= shift_next;
    oe_reg <= oe_next;
    index_reg <= index_next;
    hold_reg <= hold_next;
    int_reset_reg <= int_reset_next;
    reset_count_reg <= reset_count_next;
    done_reg <= done_next;
  end
end

assign pixel_select = shift_reg;
assign analog_pixel_out_oe = oe_reg;
assign pixel_index = index_reg;
assign sample_hold = hold_reg;
assign integrator_reset = int_reset_reg;
assign frame_done = done_reg;

endmodule

// *** verif/readout_assertions.sv ***
// port checker for the readout sequencer
module readout_chk(input wire clock, srst, start_pulse, analog_pixel_out_oe, sample_hold, integrator_reset,
  input wire [127:0] pixel_select, input wire [6:0] pixel_index);
  timeunit 1ns / 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_shift_step: assert property (!$past(srst) |->
    pixel_select[127:1] == $past(pixel_select[126:0])) else $error("shift");
  a_pixel_index: assert property (analog_pixel_out_oe |->
    pixel_select == 128'h1 << pixel_index) else $error("index");
  a_reset_len: assert property (start_pulse |-> ##18 integrator_reset ##1 !integrator_reset) else $error("len");
  a_hold_tied: assert property (sample_hold == integrator_reset) else $error("hold");
  a_start_capture: assert property (start_pulse |=> pixel_select[0] && sample_hold && integrator_reset) else $error("cap");
  a_idle_hiz: assert property (analog_pixel_out_oe == |pixel_select) else $error("hiz");
  cover property (start_pulse);
  cover property ($fell(integrator_reset));
  cover property ($fell(analog_pixel_out_oe));
endmodule
bind linear_sensor_readout_sequencer readout_chk u_chk(.*);

// *** verif/ctl_model.sv ***
// controller model: one-clock start pulses
module ctl_model(input wire clock, fire, output logic start_pulse = 0);
  timeunit 1ns / 1ns;
  always @(posedge clock) start_pulse <= #1 fire & ~start_pulse;
endmodule

// *** verif/tb_top.sv ***
// bench: randomly spaced frames against a cycle model
module tb_top;
  timeunit 1ns / 1ns;
  logic clock = 0, srst = 1, fire = 0;
  wire start_pulse, analog_pixel_out_oe, sample_hold, integrator_reset, frame_done;
  wire [127:0] pixel_select;
  wire [6:0] pixel_index;
  int err_count, compares, t, cyc, seed = 56;
  bit b;
  always #50 clock = ~clock;
  ctl_model u_ctl(.*);
  linear_sensor_readout_sequencer u_dut(.*);
  task chk(logic [138:0] e, s);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch outputs exp %h seen %h", e, s);
    end
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    t = srst ? 999 : start_pulse ? 0 : t + 1;
    b = t < 128;
    if (++cyc > 8000)
    begin
      err_count++;
      end_of_test;
    end
  end
  always @(negedge clock)
    chk({b ? 128'h1 << t : 128'h0, b, b ? t[6:0] : 7'h0, t < 18, t < 18, t == 128},
      {pixel_select, analog_pixel_out_oe, pixel_index, sample_hold, integrator_reset, frame_done});
  initial
  begin
    repeat (16) @(posedge clock);
    #1 srst = 0;
    repeat (8)
    begin
      fire = 1;
      @(posedge clock) #1 fire = 0;
      repeat (663 + {$random(seed)} % 8) @(posedge clock);
      #1;
    end
    end_of_test;
  end
endmodule
